// >>> tb/cpb_codec_model.sv
// Behavioural codec model driving the serial side of the port
`timescale 1ns/1ps
module cpb_codec_model (
	output logic sck,
	output logic fs,
	output logic sdi,
	input wire logic sdo
);
	// ==========================================================
	// Frame contents
	logic [15:0] in_word [16];
	logic [15:0] out_seen [5];

	// Idle levels at time zero
	initial begin
		sck = 1'b0;
		fs = 1'b0;
		sdi = 1'b0;
	end

	// Bit clocks with no frame, used while reset is held and before each frame
	task automatic idle(input int n);
		repeat (n) begin
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
	endtask

	// One frame: a few free bit clocks let staged words and masks cross,
	// then sync at rise 0, 16 slots MSB first; clock stops after
	task automatic frame();
		idle(8);
		fs = 1'b1;
		#6;
		for (int i = 0; i < 260; i++) begin
			sck = 1'b1;
			#6 sck = 1'b0;
			fs = 1'b0;
			// Sample the port's output half a bit after it launched
			if (i < 80)
				out_seen[i/16][15-i%16] = sdo;
			// Next bit; past the last slot the line keeps toggling
			if (i < 256)
				sdi = in_word[i/16][15-i%16];
			else
				sdi = ~sdi;
			#6;
		end
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the codec port buffer and interrupt pacing
`timescale 1ns/1ps
module testbench;
	logic clock;
	logic reset_n;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic sck;
	logic fs;
	logic sdi;
	logic sdo;
	logic irq;
	logic [31:0] v;
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;
	// Rows: length select beside the slot mask that fills it in one frame
	logic [1:0] row_buffer_length_sel [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic [15:0] row_mask [4] = '{16'h0001, 16'h0003, 16'h0007, 16'h000f};

	cpb_top uut (
		.CLOCK(clock),
		.RESET_N(reset_n),
		.ADDR(addr),
		.WDATA(wdata),
		.WR(wr),
		.RD(rd),
		.RDATA(rdata),
		.SERIAL_BIT_CLOCK(sck),
		.FRAME_SYNC(fs),
		.SERIAL_DATA_IN(sdi),
		.SERIAL_DATA_OUT(sdo),
		.PORT_IRQ_FLAG(irq)
	);

	cpb_codec_model codec (.sck(sck), .fs(fs), .sdi(sdi), .sdo(sdo));

	// ==========================================================
	// Clock and hang guard
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			results();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1;
	endtask

	task automatic reg_read(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Run one frame and let the flag cross into the register side
	task automatic run_frame();
		codec.frame();
		repeat (10) @(posedge clock);
	endtask

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		reset_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		codec.idle(4);
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		check({31'h0, irq}, 32'h0);
		check({31'h0, sdo}, 32'h0);
		reg_read(cpb_pkg::OFF_CONTROL_TWO);
		check(v, 32'h0);
		reg_read(cpb_pkg::OFF_TX_SLOT_MASK);
		check(v, 32'h0);
		reg_write(cpb_pkg::OFF_CONTROL_TWO, 32'hffffffff);
		reg_read(cpb_pkg::OFF_CONTROL_TWO);
		check(v, 32'h00000c00);
		reg_write(8'h40, 32'hffffffff);
		reg_read(8'h40);
		check(v, 32'h0);
		$display("test reset and fields done");
		// Each length filled within one frame
		for (int r = 0; r < 4; r++) begin
			reg_write(cpb_pkg::OFF_CONTROL_TWO, {20'h0, row_buffer_length_sel[r], 10'h0});
			reg_write(cpb_pkg::OFF_TX_SLOT_MASK, {16'h0, row_mask[r]});
			reg_write(cpb_pkg::OFF_RX_SLOT_MASK, {16'h0, row_mask[r]});
			for (int k = 0; k < 16; k++) begin
				codec.in_word[k] = 16'(16'h3a00 + 16 * r + k);
				if (k < 4)
					reg_write(cpb_pkg::OFF_TX_HOLD0 + 8'(4 * k),
						32'(16'h9c00 + 16 * r + k));
			end
			run_frame();
			check({31'h0, irq}, 32'h1);
			for (int k = 0; k <= int'(row_buffer_length_sel[r]); k++) begin
				check({16'h0, codec.out_seen[k]}, 32'(16'h9c00 + 16 * r + k));
				reg_read(cpb_pkg::OFF_RX_HOLD0 + 8'(4 * k));
				check(v, 32'(16'h3a00 + 16 * r + k));
			end
			check({16'h0, codec.out_seen[row_buffer_length_sel[r] + 1]}, 32'h0);
			check({31'h0, irq}, 32'h1);
			reg_write(cpb_pkg::OFF_STATUS, 32'h1);
			check({31'h0, irq}, 32'h0);
			$display("test row %0d done", r);
		end
		// Four words, slot zero only: one word per frame over four frames
		reg_write(cpb_pkg::OFF_CONTROL_TWO, 32'h00000c00);
		reg_write(cpb_pkg::OFF_TX_SLOT_MASK, 32'h1);
		reg_write(cpb_pkg::OFF_RX_SLOT_MASK, 32'h1);
		for (int k = 0; k < 4; k++)
			reg_write(cpb_pkg::OFF_TX_HOLD0 + 8'(4 * k), 32'(16'h7100 + k));
		for (int f = 0; f < 4; f++) begin
			codec.in_word[0] = 16'(16'ha5f0 + f);
			run_frame();
			check({31'h0, irq}, {31'h0, f == 3});
			check({16'h0, codec.out_seen[0]}, 32'(16'h7100 + f));
			check({16'h0, codec.out_seen[1]}, 32'h0);
			reg_read(cpb_pkg::OFF_STATUS);
			check(v, 32'((((f + 1) % 4) << 4) + (f == 3)));
		end
		for (int k = 0; k < 4; k++) begin
			reg_read(cpb_pkg::OFF_RX_HOLD0 + 8'(4 * k));
			check(v, 32'(16'ha5f0 + k));
		end
		reg_write(cpb_pkg::OFF_STATUS, 32'h0);
		check({31'h0, irq}, 32'h1);
		reg_read(cpb_pkg::OFF_STATUS);
		check(v, 32'h1);
		reg_write(cpb_pkg::OFF_STATUS, 32'h1);
		$display("test four frames done");
		// One word length: location restarts at zero, flag stays set
		reg_write(cpb_pkg::OFF_CONTROL_TWO, 32'h0);
		codec.in_word[0] = 16'h0f0f;
		run_frame();
		check({31'h0, irq}, 32'h1);
		reg_read(cpb_pkg::OFF_RX_HOLD0);
		check(v, 32'h0f0f);
		codec.in_word[0] = 16'hf0f0;
		run_frame();
		check({31'h0, irq}, 32'h1);
		reg_read(cpb_pkg::OFF_RX_HOLD0);
		check(v, 32'hf0f0);
		$display("test one word restart done");
		results();
	end
endmodule

// >>> verilog/cpb_link.sv
// Serial side of the port: slot timing, shifting and word events
`timescale 1ns/1ps
module cpb_link #(
	parameter int W = cpb_pkg::WORD_W,
	parameter int S = cpb_pkg::SLOTS
) (
	input wire logic sck,
	input wire logic rst_n,
	input wire logic fs,
	input wire logic sdi,
	output logic sdo,
	input wire logic [S-1:0] tx_mask_cpu,
	input wire logic [S-1:0] rx_mask_cpu,
	input wire logic [W-1:0] tx_word,
	input wire logic tx_load_tg,
	output logic [W-1:0] rx_word,
	output logic rx_tg,
	output logic tx_tg
);
	localparam int BW = $clog2(W);
	localparam int SW = $clog2(S);
	localparam logic [BW-1:0] LAST_BIT = BW'(W - 1);
	localparam logic [SW-1:0] LAST_SLOT = SW'(S - 1);

	logic [S-1:0] tx_m;
	logic [S-1:0] rx_m;
	logic load_lvl;
	logic load_seen, next_load_seen;
	logic [BW-1:0] bit_cnt, next_bit_cnt;
	logic [SW-1:0] slot, next_slot;
	logic active, next_active;
	logic [W-1:0] tx_sh, next_tx_sh;
	logic [W-1:0] rx_sh, next_rx_sh;
	logic [W-1:0] shadow, next_shadow;
	logic [W-1:0] next_rx_word;
	logic next_rx_tg, next_tx_tg;
	logic slot_end;
	logic start;
	logic [SW-1:0] up_slot;

	// ==========================================================
	// Crossings from the register side
	cpb_sync #(.W(2 * S + 1)) u_cfg_sync (
		.clk(sck),
		.rst_n(rst_n),
		.d({tx_mask_cpu, rx_mask_cpu, tx_load_tg}),
		.q({tx_m, rx_m, load_lvl})
	);

	// ==========================================================
	// Slot timing: data begins one bit clock after frame sync
	assign slot_end = active && (bit_cnt == LAST_BIT);
	assign start = fs || (slot_end && (slot != LAST_SLOT));
	assign up_slot = fs ? '0 : slot + SW'(1);

	always_comb begin
		next_bit_cnt = bit_cnt;
		next_slot = slot;
		next_active = active;
		next_tx_sh = {tx_sh[W-2:0], 1'b0};
		next_rx_sh = active ? {rx_sh[W-2:0], sdi} : rx_sh;
		next_rx_word = rx_word;
		next_rx_tg = rx_tg;
		next_tx_tg = tx_tg;
		next_load_seen = load_lvl;
		next_shadow = (load_lvl != load_seen) ? tx_word : shadow;
		// Close the slot: toggle rx_tg if the slot is used, capturing the word only if it receives
		if (slot_end) begin
			if (tx_m[slot] || rx_m[slot]) begin
				next_rx_word = rx_m[slot] ? {rx_sh[W-2:0], sdi} : '0;
				next_rx_tg = ~rx_tg;
			end
			if (slot == LAST_SLOT)
				next_active = 1'b0;
		end
		// Open the next slot: take the staged word if the slot transmits, toggle tx_tg if it is used
		if (start) begin
			next_bit_cnt = '0;
			next_slot = up_slot;
			next_active = 1'b1;
			next_tx_sh = '0;
			if (tx_m[up_slot] || rx_m[up_slot]) begin
				next_tx_tg = ~tx_tg;
				if (tx_m[up_slot])
					next_tx_sh = shadow;
			end
		end else if (active) begin
			next_bit_cnt = bit_cnt + BW'(1);
		end
	end

	// Serial state register
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= '0;
			slot <= '0;
			active <= 1'b0;
			tx_sh <= '0;
			rx_sh <= '0;
			shadow <= '0;
			rx_word <= '0;
			rx_tg <= 1'b0;
			tx_tg <= 1'b0;
			load_seen <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			slot <= next_slot;
			active <= next_active;
			tx_sh <= next_tx_sh;
			rx_sh <= next_rx_sh;
			shadow <= next_shadow;
			rx_word <= next_rx_word;
			rx_tg <= next_rx_tg;
			tx_tg <= next_tx_tg;
			load_seen <= next_load_seen;
		end
	end

	// Output bit straight from the shifter
	assign sdo = tx_sh[W-1];

	// ==========================================================
	// Checks on the serial side
	unused_slot_a: assert property (@(posedge sck) disable iff (!rst_n)
		slot_end && !tx_m[slot] && !rx_m[slot] |=> $stable(rx_tg))
		else $error("Word event in an unused slot");
	used_slot_a: assert property (@(posedge sck) disable iff (!rst_n)
		slot_end && (tx_m[slot] || rx_m[slot]) |=> rx_tg != $past(rx_tg))
		else $error("Used slot closed without a word event");
	frame_start_a: assert property (@(posedge sck) disable iff (!rst_n)
		fs |=> active && slot == '0 && bit_cnt == '0)
		else $error("Frame sync did not open slot zero");
	slot_cov: cover property (@(posedge sck) disable iff (!rst_n)
		slot_end && slot == '0 && tx_m[0]);
endmodule

// >>> verilog/cpb_pkg.sv
// Constants shared by the codec port buffer and interrupt pacing block
package cpb_pkg;
	// ==========================================================
	// Register offsets (byte addresses on the register port)
	localparam logic [7:0] OFF_CONTROL_TWO = 8'h00;
	localparam logic [7:0] OFF_TX_SLOT_MASK = 8'h04;
	localparam logic [7:0] OFF_RX_SLOT_MASK = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_TX_HOLD0 = 8'h10;
	localparam logic [7:0] OFF_RX_HOLD0 = 8'h20;
	// ==========================================================
	// Field positions
	localparam int BUFFER_LENGTH_SEL_LSB = 10;
	localparam int BUFFER_LENGTH_SEL_MSB = 11;
	localparam int IRQ_BIT = 0;
	localparam int IDX_LSB = 4;
	localparam int IDX_MSB = 5;
	// ==========================================================
	// Sizes and reset values
	localparam int WORD_W = 16;
	localparam int SLOTS = 16;
	localparam int HOLD_WORDS = 4;
	localparam logic [1:0] BUFFER_LENGTH_SEL_RESET = 2'h0;
	localparam logic [15:0] MASK_RESET = 16'h0000;
endpackage

// >>> verilog/cpb_sync.sv
// Three-stage synchroniser with an agreement filter on the last two stages
`timescale 1ns/1ps
module cpb_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// A bit takes a new value only once stages two and three agree
	always_comb begin
		next_q = q;
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i])
				next_q[i] = s3[i];
		end
	end

	// Stage one feeds stage two only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end
endmodule

// >>> verilog/cpb_top.sv
// Codec port buffering and interrupt pacing, register side and top level
// ============================================================
// What this block does
// - Holds up to four words per direction; length select 00=one, 11=four.
// - Buffered words go to enabled slots, within one frame or across several.
// - Slot zero only enabled: one word out and in per frame, slot zero.
// - Length one word: interrupt flag rises after each word exchanged.
// - Four words, slot zero only: flag rises once per four frames.
// - Length select sits in bits 11 down to 10 of control register two.
`timescale 1ns/1ps
module cpb_top #(
	parameter int W = cpb_pkg::WORD_W,
	parameter int S = cpb_pkg::SLOTS
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic SERIAL_BIT_CLOCK,
	input wire logic FRAME_SYNC,
	input wire logic SERIAL_DATA_IN,
	output logic SERIAL_DATA_OUT,
	output logic PORT_IRQ_FLAG
);
	localparam int N = cpb_pkg::HOLD_WORDS;

	logic [1:0] buffer_length_sel, next_buffer_length_sel;
	logic [S-1:0] tx_slot_enable_mask, next_tx_slot_enable_mask;
	logic [S-1:0] rx_slot_enable_mask, next_rx_slot_enable_mask;
	logic [W-1:0] tx_holding_word [N];
	logic [W-1:0] next_tx_holding_word [N];
	logic [W-1:0] rx_holding_word [N];
	logic [W-1:0] next_rx_holding_word [N];
	logic [1:0] tx_idx, next_tx_idx;
	logic [1:0] rx_idx, next_rx_idx;
	logic port_irq_flag, next_port_irq_flag;
	logic [W-1:0] tx_next, next_tx_next;
	logic tx_load_tg, next_tx_load_tg;
	logic [31:0] next_rdata;
	logic rx_lvl, rx_seen, next_rx_seen;
	logic tx_lvl, tx_seen, next_tx_seen;
	logic rx_evt, tx_evt;
	logic [W-1:0] link_rx_word;
	logic link_rx_tg, link_tx_tg;
	logic serial_data_out;
	logic irq_clear;
	logic [1:0] tx_idx_adv;

	// ==========================================================
	// Serial side in the bit clock domain
	// Masks cross as quasi-static settings: change them only while the
	// link is idle, or a slot may see a mix of old and new mask bits.
	// The staged transmit word crosses beside a toggle, so the link only
	// copies it once that toggle has settled on its own side.
	cpb_link #(.W(W), .S(S)) u_link (
		.sck(SERIAL_BIT_CLOCK),
		.rst_n(RESET_N),
		.fs(FRAME_SYNC),
		.sdi(SERIAL_DATA_IN),
		.sdo(serial_data_out),
		.tx_mask_cpu(tx_slot_enable_mask),
		.rx_mask_cpu(rx_slot_enable_mask),
		.tx_word(tx_next),
		.tx_load_tg(tx_load_tg),
		.rx_word(link_rx_word),
		.rx_tg(link_rx_tg),
		.tx_tg(link_tx_tg)
	);

	assign SERIAL_DATA_OUT = serial_data_out;

	// ==========================================================
	// Word events back into the register clock domain
	// Each word event is a toggle, never a pulse, so no event is lost
	// however the two clocks slide against each other.
	cpb_sync #(.W(2)) u_evt_sync (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.d({link_rx_tg, link_tx_tg}),
		.q({rx_lvl, tx_lvl})
	);

	assign rx_evt = rx_lvl != rx_seen;
	assign tx_evt = tx_lvl != tx_seen;
	assign irq_clear = WR && (ADDR == cpb_pkg::OFF_STATUS)
		&& WDATA[cpb_pkg::IRQ_BIT];
	// Location after the one the link just took, wrapping at the length.
	// Comparing with >= keeps the walk inside the buffer when software
	// shortens the length while a buffer period is half done.
	assign tx_idx_adv = (tx_idx >= buffer_length_sel) ? 2'h0
		: tx_idx + 2'h1;

	// ==========================================================
	// Next values of the register file and buffer pacing
	always_comb begin
		next_buffer_length_sel = buffer_length_sel;
		next_tx_slot_enable_mask = tx_slot_enable_mask;
		next_rx_slot_enable_mask = rx_slot_enable_mask;
		next_tx_holding_word = tx_holding_word;
		next_rx_holding_word = rx_holding_word;
		next_tx_idx = tx_idx;
		next_rx_idx = rx_idx;
		next_port_irq_flag = port_irq_flag;
		next_tx_next = tx_next;
		next_tx_load_tg = tx_load_tg;
		next_rx_seen = rx_lvl;
		next_tx_seen = tx_lvl;
		// Software writes
		if (WR) begin
			case (ADDR)
				cpb_pkg::OFF_CONTROL_TWO: next_buffer_length_sel =
					WDATA[cpb_pkg::BUFFER_LENGTH_SEL_MSB:cpb_pkg::BUFFER_LENGTH_SEL_LSB];
				cpb_pkg::OFF_TX_SLOT_MASK:
					next_tx_slot_enable_mask = WDATA[S-1:0];
				cpb_pkg::OFF_RX_SLOT_MASK:
					next_rx_slot_enable_mask = WDATA[S-1:0];
				default: ;
			endcase
			for (int i = 0; i < N; i++) begin
				if (ADDR == cpb_pkg::OFF_TX_HOLD0 + 8'(4 * i))
					next_tx_holding_word[i] = WDATA[W-1:0];
			end
		end
		// Software clear of the flag; a set below overrides it
		if (irq_clear)
			next_port_irq_flag = 1'b0;
		// Link took a word: stage the next location's word
		// The next word is fetched as soon as the link opens a used slot,
		// so software has until the next used slot begins, less the
		// crossing time, to refill that location.
		if (tx_evt) begin
			next_tx_idx = tx_idx_adv;
			next_tx_next = next_tx_holding_word[tx_idx_adv];
			next_tx_load_tg = ~tx_load_tg;
		end else if (WR && ADDR == cpb_pkg::OFF_TX_HOLD0
				+ 8'({tx_idx, 2'h0})) begin
			next_tx_next = WDATA[W-1:0];
			next_tx_load_tg = ~tx_load_tg;
		end
		// Link delivered a word: store it and pace the interrupt
		// The flag is set last, so a clear in the same cycle loses
		if (rx_evt) begin
			next_rx_holding_word[rx_idx] = link_rx_word;
			if (rx_idx >= buffer_length_sel) begin
				next_rx_idx = 2'h0;
				next_port_irq_flag = 1'b1;
			end else begin
				next_rx_idx = rx_idx + 2'h1;
			end
		end
	end

	// Read data, valid in the cycle after the read strobe
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (RD) begin
			case (ADDR)
				cpb_pkg::OFF_CONTROL_TWO:
					next_rdata[cpb_pkg::BUFFER_LENGTH_SEL_MSB:cpb_pkg::BUFFER_LENGTH_SEL_LSB] =
						buffer_length_sel;
				cpb_pkg::OFF_TX_SLOT_MASK:
					next_rdata[S-1:0] = tx_slot_enable_mask;
				cpb_pkg::OFF_RX_SLOT_MASK:
					next_rdata[S-1:0] = rx_slot_enable_mask;
				cpb_pkg::OFF_STATUS: begin
					next_rdata[cpb_pkg::IRQ_BIT] = port_irq_flag;
					next_rdata[cpb_pkg::IDX_MSB:cpb_pkg::IDX_LSB] = rx_idx;
				end
				default: ;
			endcase
			for (int i = 0; i < N; i++) begin
				if (ADDR == cpb_pkg::OFF_TX_HOLD0 + 8'(4 * i))
					next_rdata[W-1:0] = tx_holding_word[i];
				if (ADDR == cpb_pkg::OFF_RX_HOLD0 + 8'(4 * i))
					next_rdata[W-1:0] = rx_holding_word[i];
			end
		end
	end

	// Register everything; the flag output is a second flip-flop loaded with the
	// same next value as the flag register, so the pin comes straight from a flip-flop
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			buffer_length_sel <= cpb_pkg::BUFFER_LENGTH_SEL_RESET;
			tx_slot_enable_mask <= cpb_pkg::MASK_RESET;
			rx_slot_enable_mask <= cpb_pkg::MASK_RESET;
			for (int i = 0; i < N; i++) begin
				tx_holding_word[i] <= '0;
				rx_holding_word[i] <= '0;
			end
			tx_idx <= 2'h0;
			rx_idx <= 2'h0;
			port_irq_flag <= 1'b0;
			tx_next <= '0;
			tx_load_tg <= 1'b0;
			rx_seen <= 1'b0;
			tx_seen <= 1'b0;
			RDATA <= 32'h0000_0000;
			PORT_IRQ_FLAG <= 1'b0;
		end else begin
			buffer_length_sel <= next_buffer_length_sel;
			tx_slot_enable_mask <= next_tx_slot_enable_mask;
			rx_slot_enable_mask <= next_rx_slot_enable_mask;
			tx_holding_word <= next_tx_holding_word;
			rx_holding_word <= next_rx_holding_word;
			tx_idx <= next_tx_idx;
			rx_idx <= next_rx_idx;
			port_irq_flag <= next_port_irq_flag;
			tx_next <= next_tx_next;
			tx_load_tg <= next_tx_load_tg;
			rx_seen <= next_rx_seen;
			tx_seen <= next_tx_seen;
			RDATA <= next_rdata;
			PORT_IRQ_FLAG <= next_port_irq_flag;
		end
	end

	// ==========================================================
	// Checks on the register side
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	// Receive walk and flag pacing; the flag is set by the word that
	// fills the last location of the chosen length
	one_word_irq_a: assert property (
		rx_evt && buffer_length_sel == 2'h0 |=> port_irq_flag)
		else $error("Flag not raised after a single word");
	four_word_pace_a: assert property (
		rx_evt && buffer_length_sel == 2'h3 && rx_idx != 2'h3
		&& !port_irq_flag |=> !port_irq_flag)
		else $error("Flag raised before four words");
	flag_sticky_a: assert property (
		port_irq_flag && !irq_clear |=> port_irq_flag)
		else $error("Flag dropped without a software clear");
	wrap_index_a: assert property (
		rx_evt && rx_idx >= buffer_length_sel |=> rx_idx == 2'h0
		&& port_irq_flag)
		else $error("Index did not restart at location zero");
	step_index_a: assert property (
		rx_evt && rx_idx < buffer_length_sel
		|=> rx_idx == $past(rx_idx) + 2'h1)
		else $error("Index did not step by one");
	idle_index_a: assert property (
		!rx_evt |=> $stable(rx_idx))
		else $error("Index moved without a word");
	word_store_a: assert property (
		rx_evt |=> rx_holding_word[$past(rx_idx)] == $past(link_rx_word))
		else $error("Received word not stored at its location");
	length_field_a: assert property (
		WR && ADDR == cpb_pkg::OFF_CONTROL_TWO ##1 RD
		&& ADDR == cpb_pkg::OFF_CONTROL_TWO
		|=> RDATA[11:10] == $past(WDATA[11:10], 2))
		else $error("Length select not at bits 11 to 10");
	pin_flag_a: assert property (
		$rose(port_irq_flag) && !irq_clear |=> PORT_IRQ_FLAG)
		else $error("Flag output lags the flag");
	hold_quiet_a: assert property (
		!rx_evt |=> $stable(rx_holding_word[rx_idx]))
		else $error("Receive location changed without a word");

	// Transmit walk mirrors the receive walk
	tx_wrap_a: assert property (
		tx_evt && tx_idx >= buffer_length_sel |=> tx_idx == 2'h0)
		else $error("Transmit location did not restart at zero");
	tx_step_a: assert property (
		tx_evt && tx_idx < buffer_length_sel
		|=> tx_idx == $past(tx_idx) + 2'h1)
		else $error("Transmit location did not step by one");
	tx_idle_a: assert property (
		!tx_evt |=> $stable(tx_idx))
		else $error("Transmit location moved without a word");
	tx_stage_a: assert property (
		tx_evt |=> tx_next == tx_holding_word[tx_idx])
		else $error("Staged word is not the next location");

	// A word that ends a buffer beats a clear in the same cycle
	set_wins_a: assert property (
		rx_evt && rx_idx >= buffer_length_sel && irq_clear
		|=> port_irq_flag)
		else $error("Clear beat the flag set");
	flag_clear_a: assert property (
		irq_clear && !(rx_evt && rx_idx >= buffer_length_sel)
		|=> !port_irq_flag)
		else $error("Software clear did not drop the flag");
	status_read_a: assert property (
		RD && ADDR == cpb_pkg::OFF_STATUS
		|=> RDATA[cpb_pkg::IRQ_BIT] == $past(port_irq_flag))
		else $error("Status read does not show the flag");
	length_only_a: assert property (
		RD && ADDR == cpb_pkg::OFF_CONTROL_TWO
		|=> RDATA[9:0] == 10'h000 && RDATA[31:12] == 20'h00000)
		else $error("Control read shows bits outside the length");

	irq_cov: cover property ($rose(port_irq_flag));
	tx_wrap_cov: cover property (tx_evt && tx_idx == 2'h3);
	four_cov: cover property (rx_evt && buffer_length_sel == 2'h3
		&& rx_idx == 2'h3);
	clear_cov: cover property (port_irq_flag ##1 irq_clear);
endmodule
